// ---- hw/dmrc_map.vh ----
`ifndef DMRC_MAP_VH
`define DMRC_MAP_VH

// ==========================================================
// Clock and chip timing
`define DMRC_CLK_NS      40
`define DMRC_ACC_NS      285
`define DMRC_ACC_CYC     ((`DMRC_ACC_NS + `DMRC_CLK_NS - 1) / `DMRC_CLK_NS)
`define DMRC_REF_NS      14000
`define DMRC_REF_CYC     (`DMRC_REF_NS / `DMRC_CLK_NS)

// ==========================================================
// Array geometry
`define DMRC_FIELDS      8
`define DMRC_WORD_W      12
`define DMRC_MUX_W       7
`define DMRC_ROWS_4K     64
`define DMRC_ROWS_16K    128

// ==========================================================
// Word address fields
`define DMRC_ROW_LSB     6
`define DMRC_ROW_MSB     11
`define DMRC_COL_LSB     0
`define DMRC_COL_MSB     5
`define DMRC_EXT_ROW     2
`define DMRC_EXT_COL     1
`define DMRC_EXT_HALF    0

`endif

// ---- hw/dmrc_ctrl.v ----
// Functional notes
// - 4K chips: 12-bit cell address sent as two 6-bit halves.
// - 16K chips: 14-bit cell address sent as two 7-bit halves.
// - Row strobe latches row first, column strobe afterwards.
// - Read data valid from access time until next column strobe.
// - Read: write enable high; 4K chip select asserted at column strobe.
// - Write: write enable low before access; 4K needs chip select.
// - Write data bit presented before column strobe falls.
// - Refresh cycle started about every 14 us regardless of accesses.
// - Each refresh uses next row, covering 64 or 128 rows.
// - Refresh issues row strobe only; column strobe stays inactive.
// - 4K: chip select inactive during refresh.
// - Row strobe to selected field only; column strobe to all.
// - Read data produced within first third of processor cycle.
// - Every write done as read then write to same location.
// - Pending refresh may run between read and write portions.
// - Row time: word address bits 6..11, plus extended bit 2 on 16K.
// - Column time: word address bits 0..5, plus extended bit 1 on 16K.
// - Eight fields of twelve one-bit chips, one bit each.
// - 4K: three extended bits decoded by two 2:4 decoders.
// - One field strobe low per access, all eight on refresh.
// - 16K: segment line picks 32K region, extended bit 0 the half.
// - Module reacts only while module selected is high.
`timescale 1ns/100ps
`include "dmrc_map.vh"

module dmrc_ctrl (
  input  wire        CLOCK,
  input  wire        ARST_N,
  input  wire        CLK_EN,
  input  wire        VARIANT_16K,
  input  wire        TIMING_PULSE_FOUR,
  input  wire        CYCLE_BEGIN,
  input  wire        MODULE_SELECTED,
  input  wire        WRITE_REQ,
  input  wire [11:0] WORD_ADDRESS,
  input  wire [2:0]  EXTENDED_ADDRESS,
  input  wire [3:0]  SEGMENT_ENABLE,
  input  wire [11:0] WRITE_DATA,
  input  wire [11:0] CHIP_DOUT,
  output reg  [6:0]  CHIP_MUX_ADDRESS,
  output reg  [7:0]  ROW_STROBE_N,
  output reg         COL_STROBE_N,
  output reg         CHIP_SELECT_N,
  output reg         CHIP_WRITE_N,
  output reg  [11:0] CHIP_DIN,
  output reg  [11:0] READ_DATA,
  output reg         READ_VALID,
  output reg         REFRESH_BUSY
);

  // ==========================================================
  // States
  localparam [9:0] S_IDLE = 10'h001;
  localparam [9:0] S_RROW = 10'h002;
  localparam [9:0] S_RMUX = 10'h004;
  localparam [9:0] S_RCAS = 10'h008;
  localparam [9:0] S_GAP  = 10'h010;
  localparam [9:0] S_WROW = 10'h020;
  localparam [9:0] S_WMUX = 10'h040;
  localparam [9:0] S_WCAS = 10'h080;
  localparam [9:0] S_REF  = 10'h100;
  localparam [9:0] S_PRE  = 10'h200;

  localparam integer ACC_N = `DMRC_ACC_CYC - 1;
  localparam integer REF_N = `DMRC_REF_CYC - 1;
  localparam [3:0] ACC_LAST = ACC_N[3:0];
  localparam [8:0] REF_LAST = REF_N[8:0];

  // ==========================================================
  // Pin synchronisers, two flops each
  reg  [47:0] sync1_reg;
  reg  [47:0] sync2_reg;
  wire [47:0] pins;

  assign pins = {VARIANT_16K, TIMING_PULSE_FOUR, CYCLE_BEGIN,
                 MODULE_SELECTED, WRITE_REQ, WORD_ADDRESS,
                 EXTENDED_ADDRESS, SEGMENT_ENABLE, WRITE_DATA,
                 CHIP_DOUT};

  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1_reg <= 48'h0;
      sync2_reg <= 48'h0;
    end else if (CLK_EN) begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end

  wire        v16_s   = sync2_reg[47];
  wire        pf_s    = sync2_reg[46];
  wire        begin_s = sync2_reg[45];
  wire        sel_s   = sync2_reg[44];
  wire        wr_s    = sync2_reg[43];
  wire [11:0] addr_s  = sync2_reg[42:31];
  wire [2:0]  ext_s   = sync2_reg[30:28];
  wire [3:0]  seg_s   = sync2_reg[27:24];
  wire [11:0] wdat_s  = sync2_reg[23:12];
  wire [11:0] dout_s  = sync2_reg[11:0];

  // ==========================================================
  // Cycle start detection
  reg         begin_d_reg;
  reg         pf_seen_reg;
  reg         req_reg;
  reg         wr_reg;
  reg  [11:0] addr_reg;
  reg  [2:0]  ext_reg;
  reg  [3:0]  seg_reg;
  reg  [11:0] wdat_reg;
  reg  [9:0]  state_reg;
  reg  [9:0]  state_next;

  wire start = begin_s & ~begin_d_reg & pf_seen_reg & sel_s;
  wire take  = (state_reg == S_IDLE) & req_reg;

  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      begin_d_reg <= 1'b0;
      pf_seen_reg <= 1'b0;
      req_reg     <= 1'b0;
      wr_reg      <= 1'b0;
      addr_reg    <= 12'h000;
      ext_reg     <= 3'h0;
      seg_reg     <= 4'h0;
    end else if (CLK_EN) begin
      begin_d_reg <= begin_s;
      if (pf_s)
        pf_seen_reg <= 1'b1;
      else if (begin_s & ~begin_d_reg)
        pf_seen_reg <= 1'b0;
      if (start) begin
        req_reg  <= 1'b1;
        wr_reg   <= wr_s;
        addr_reg <= addr_s;
        ext_reg  <= ext_s;
        seg_reg  <= seg_s;
      end else if (take) begin
        req_reg  <= 1'b0;
      end
    end
  end

  // Write data sampled late, after the read portion hands over the bus
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N)
      wdat_reg <= 12'h000;
    else if (CLK_EN && state_reg == S_GAP)
      wdat_reg <= wdat_s;
  end

  // ==========================================================
  // Field select and address halves
  wire [7:0] field_sel;
  genvar f;
  generate
    for (f = 0; f < `DMRC_FIELDS; f = f + 1) begin : g_field
      assign field_sel[f] = v16_s ?
        (seg_reg[f / 2] & ({31'h0, ext_reg[`DMRC_EXT_HALF]} == f % 2)) :
        (({31'h0, ext_reg[2]} == f / 4) &
         ({30'h0, ext_reg[1:0]} == f % 4));
    end
  endgenerate

  wire [6:0] row_addr = {v16_s & ext_reg[`DMRC_EXT_ROW],
                         addr_reg[`DMRC_ROW_MSB:`DMRC_ROW_LSB]};
  wire [6:0] col_addr = {v16_s & ext_reg[`DMRC_EXT_COL],
                         addr_reg[`DMRC_COL_MSB:`DMRC_COL_LSB]};

  // ==========================================================
  // Refresh timer and row counter
  reg  [8:0] ref_tmr_reg;
  reg        ref_pend_reg;
  reg        ref_ret_reg;
  reg  [6:0] ref_row_reg;
  reg  [3:0] wait_reg;
  wire       wait_done = (wait_reg == ACC_LAST);
  wire       ref_tick  = (ref_tmr_reg == REF_LAST);
  wire       ref_go    = (state_next == S_REF) & (state_reg != S_REF);
  wire       ref_end   = (state_reg == S_REF) & wait_done;

  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ref_tmr_reg  <= 9'h000;
      ref_pend_reg <= 1'b0;
      ref_ret_reg  <= 1'b0;
      ref_row_reg  <= 7'h00;
    end else if (CLK_EN) begin
      ref_tmr_reg <= ref_tick ? 9'h000 : ref_tmr_reg + 9'h001;
      // Set wins over the clear on a coincident tick
      if (ref_tick)
        ref_pend_reg <= 1'b1;
      else if (ref_go)
        ref_pend_reg <= 1'b0;
      if (ref_go)
        ref_ret_reg <= (state_reg == S_GAP);
      if (ref_end)
        ref_row_reg <= v16_s ? ref_row_reg + 7'h01 :
                       {1'b0, ref_row_reg[5:0] + 6'h01};
    end
  end

  // ==========================================================
  // Sequencer
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (req_reg)
          state_next = S_RROW;
        else if (ref_pend_reg)
          state_next = S_REF;
      end
      S_RROW: state_next = S_RMUX;
      S_RMUX: state_next = S_RCAS;
      S_RCAS: begin
        if (wait_done)
          state_next = wr_reg ? S_GAP : S_PRE;
      end
      S_GAP: begin
        if (ref_pend_reg)
          state_next = S_REF;
        else
          state_next = S_WROW;
      end
      S_WROW: state_next = S_WMUX;
      S_WMUX: state_next = S_WCAS;
      S_WCAS: begin
        if (wait_done)
          state_next = S_PRE;
      end
      S_REF: begin
        if (wait_done)
          state_next = ref_ret_reg ? S_GAP : S_PRE;
      end
      S_PRE:   state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  wire timed = (state_reg == S_RCAS) | (state_reg == S_WCAS) |
               (state_reg == S_REF);

  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= S_IDLE;
      wait_reg  <= 4'h0;
    end else if (CLK_EN) begin
      state_reg <= state_next;
      wait_reg  <= (timed && !wait_done) ? wait_reg + 4'h1 : 4'h0;
    end
  end

  // ==========================================================
  // Chip pin drive, registered from the next state
  wire n_ras = (state_next == S_RROW) | (state_next == S_RMUX) |
               (state_next == S_RCAS) | (state_next == S_WROW) |
               (state_next == S_WMUX) | (state_next == S_WCAS);
  wire n_col = (state_next == S_RMUX) | (state_next == S_RCAS) |
               (state_next == S_WMUX) | (state_next == S_WCAS);
  wire n_cas = (state_next == S_RCAS) | (state_next == S_WCAS);
  wire n_we  = (state_next == S_WMUX) | (state_next == S_WCAS);
  wire n_wr  = (state_next == S_WROW) | n_we;
  wire n_ref = (state_next == S_REF);

  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      CHIP_MUX_ADDRESS <= 7'h00;
      ROW_STROBE_N     <= 8'hff;
      COL_STROBE_N     <= 1'b1;
      CHIP_SELECT_N    <= 1'b1;
      CHIP_WRITE_N     <= 1'b1;
      CHIP_DIN         <= 12'h000;
      REFRESH_BUSY     <= 1'b0;
    end else if (CLK_EN) begin
      if (n_ref)
        CHIP_MUX_ADDRESS <= ref_row_reg;
      else if (n_col)
        CHIP_MUX_ADDRESS <= col_addr;
      else
        CHIP_MUX_ADDRESS <= row_addr;
      if (n_ref)
        ROW_STROBE_N <= 8'h00;
      else if (n_ras)
        ROW_STROBE_N <= ~field_sel;
      else
        ROW_STROBE_N <= 8'hff;
      COL_STROBE_N  <= ~n_cas;
      CHIP_SELECT_N <= ~(n_col & ~v16_s);
      CHIP_WRITE_N  <= ~n_we;
      CHIP_DIN      <= n_wr ? wdat_reg : CHIP_DIN;
      REFRESH_BUSY  <= n_ref;
    end
  end

  // ==========================================================
  // Read capture; held until the next read replaces it
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      READ_DATA  <= 12'h000;
      READ_VALID <= 1'b0;
    end else if (CLK_EN) begin
      READ_VALID <= 1'b0;
      if (state_reg == S_RCAS && wait_done) begin
        READ_DATA  <= dout_s;
        READ_VALID <= 1'b1;
      end
    end
  end

endmodule

// ---- dv/dmrc_ctrl_sva.sv ----
`timescale 1ns/100ps
// ======================================
// Port checker
module dmrc_ctrl_sva (
  input wire        CLOCK,
  input wire        ARST_N,
  input wire        VARIANT_16K,
  input wire [6:0]  CHIP_MUX_ADDRESS,
  input wire [7:0]  ROW_STROBE_N,
  input wire        COL_STROBE_N,
  input wire        CHIP_SELECT_N,
  input wire        CHIP_WRITE_N,
  input wire [11:0] CHIP_DIN,
  input wire        READ_VALID,
  input wire        REFRESH_BUSY
);
  reg [9:0] gap_reg;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  // Saturates so a stuck timer still trips the check
  always @(posedge CLOCK or negedge ARST_N)
    if (!ARST_N) gap_reg <= 10'h000;
    else if (REFRESH_BUSY) gap_reg <= 10'h000;
    else if (gap_reg != 10'h3ff) gap_reg <= gap_reg + 10'h001;
  chk_ras_first: assert property (
    $fell(COL_STROBE_N) |-> ROW_STROBE_N != 8'hff)
    else $error("column strobe without row strobe");
  chk_cas_width: assert property (
    $fell(COL_STROBE_N) |-> !COL_STROBE_N[*8] ##1 COL_STROBE_N)
    else $error("column strobe width wrong");
  chk_ref_quiet: assert property (
    REFRESH_BUSY |-> COL_STROBE_N && CHIP_SELECT_N && CHIP_WRITE_N)
    else $error("refresh drove column side");
  chk_ref_all: assert property (
    REFRESH_BUSY |-> ROW_STROBE_N == 8'h00)
    else $error("refresh not on all fields");
  chk_one_field: assert property (
    !VARIANT_16K && !REFRESH_BUSY |-> $onehot0(~ROW_STROBE_N))
    else $error("several fields strobed");
  chk_mux_narrow: assert property (
    !VARIANT_16K |-> !CHIP_MUX_ADDRESS[6])
    else $error("seventh address line used");
  chk_cs_at_cas: assert property (
    $fell(COL_STROBE_N) && !VARIANT_16K |-> !CHIP_SELECT_N)
    else $error("chip select missing");
  chk_we_early: assert property (
    $fell(CHIP_WRITE_N) |=> $fell(COL_STROBE_N))
    else $error("write enable not ahead of strobe");
  chk_din_held: assert property (
    $fell(COL_STROBE_N) && !CHIP_WRITE_N |-> $stable(CHIP_DIN))
    else $error("write data moved at strobe");
  chk_valid_end: assert property (
    READ_VALID |-> $rose(COL_STROBE_N) ##1 !READ_VALID)
    else $error("read valid misplaced");
  chk_ref_gap: assert property (
    $rose(REFRESH_BUSY) |-> gap_reg >= 10'h12c && gap_reg <= 10'h190)
    else $error("refresh spacing wrong");
  chk_ref_due: assert property (
    gap_reg <= 10'h190)
    else $error("refresh overdue");
  cover property ($rose(READ_VALID));
  cover property ($fell(CHIP_WRITE_N));
  cover property ($rose(REFRESH_BUSY));
  cover property ($rose(COL_STROBE_N) ##1 $rose(REFRESH_BUSY));
endmodule
bind dmrc_ctrl dmrc_ctrl_sva u_sva (
  .CLOCK(CLOCK), .ARST_N(ARST_N), .VARIANT_16K(VARIANT_16K),
  .CHIP_MUX_ADDRESS(CHIP_MUX_ADDRESS), .ROW_STROBE_N(ROW_STROBE_N),
  .COL_STROBE_N(COL_STROBE_N), .CHIP_SELECT_N(CHIP_SELECT_N),
  .CHIP_WRITE_N(CHIP_WRITE_N), .CHIP_DIN(CHIP_DIN),
  .READ_VALID(READ_VALID), .REFRESH_BUSY(REFRESH_BUSY));

// ---- dv/dmrc_proc.sv ----
`timescale 1ns/100ps
// ======================================
// Processor model, one cycle per call
module dmrc_proc (
  input  wire        clock,
  input  wire        read_valid,
  input  wire [11:0] read_data,
  output reg         timing_pulse_four = 1'b0,
  output reg         cycle_begin = 1'b0,
  output reg         write_req = 1'b0,
  output reg  [11:0] word_address = 12'h000,
  output reg  [11:0] write_data = 12'h000,
  output reg  [2:0]  extended_address = 3'h0
);
  integer n;
  task run(input wr, input [11:0] a, input [11:0] d, input [2:0] e,
           output [11:0] got, output ok);
    begin
      got = 12'h000;
      ok = 1'b0;
      @(posedge clock);
      // address set with the timing pulse
      {timing_pulse_four, write_req, word_address} <= {1'b1, wr, a};
      {write_data, extended_address} <= {d, e};
      @(posedge clock);
      timing_pulse_four <= 1'b0;
      repeat (2) @(posedge clock);
      // begin rises after the timing pulse
      cycle_begin <= 1'b1;
      for (n = 0; n < 40 && !ok; n = n + 1) begin
        @(posedge clock);
        if (read_valid === 1'b1) begin
          ok = 1'b1;
          got = read_data;
        end
      end
      // held through the write portion too
      repeat (32) @(posedge clock);
      // Released lines show the inverse, not a stale copy
      {cycle_begin, word_address} <= {1'b0, ~a};
      {write_data, extended_address} <= {~d, ~e};
    end
  endtask
endmodule

// ---- dv/dmrc_ctrl_tb.sv ----
`timescale 1ns/100ps
// ======================================
// Bench
module dmrc_ctrl_tb;
  reg         clock = 1'b0;
  reg         arst_n = 1'b0;
  reg         v16 = 1'b0;
  reg         sel = 1'b1;
  reg  [3:0]  seg = 4'h4;
  reg  [11:0] dout = 12'h000;
  wire        tpf, beg, wreq, rvalid, rbusy, cas_n, cs_n, we_n;
  wire [11:0] wa, wd, din, rdata;
  wire [2:0]  ea;
  wire [6:0]  mux;
  wire [7:0]  ras_n;
  reg  [7:0]  ras_q = 8'hff, fld;
  reg         cas_q = 1'b1, rb_q = 1'b0, cs_s, we_s, o;
  reg  [6:0]  row_s, col_s, ref_row, prev;
  reg  [11:0] din_s, g;
  integer     bad_count = 0, n_checks = 0, ref_cnt = 0, k, n, c;
  always #20 clock = ~clock;
  dmrc_proc u_proc (.clock(clock), .read_valid(rvalid), .read_data(rdata),
    .timing_pulse_four(tpf), .cycle_begin(beg), .write_req(wreq),
    .word_address(wa), .write_data(wd), .extended_address(ea));
  dmrc_ctrl dut (.CLOCK(clock), .ARST_N(arst_n), .CLK_EN(1'b1),
    .VARIANT_16K(v16), .TIMING_PULSE_FOUR(tpf), .CYCLE_BEGIN(beg),
    .MODULE_SELECTED(sel), .WRITE_REQ(wreq), .WORD_ADDRESS(wa),
    .EXTENDED_ADDRESS(ea), .SEGMENT_ENABLE(seg), .WRITE_DATA(wd),
    .CHIP_DOUT(dout), .CHIP_MUX_ADDRESS(mux), .ROW_STROBE_N(ras_n),
    .COL_STROBE_N(cas_n), .CHIP_SELECT_N(cs_n), .CHIP_WRITE_N(we_n),
    .CHIP_DIN(din), .READ_DATA(rdata), .READ_VALID(rvalid),
    .REFRESH_BUSY(rbusy));
  always @(posedge clock) begin
    if (ras_n != 8'hff && ras_q == 8'hff && !rbusy)
      {fld, row_s} <= {ras_n, mux};
    if (!cas_n && cas_q)
      {col_s, cs_s, we_s, din_s} <= {mux, cs_n, we_n, din};
    if (rbusy && !rb_q) begin
      ref_row <= mux;
      ref_cnt <= ref_cnt + 1;
    end
    {ras_q, cas_q, rb_q} <= {ras_n, cas_n, rbusy};
  end
  task check(input string what, input [11:0] seen, input [11:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("Error %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task access(input wr, input [11:0] a, input [2:0] e, input [11:0] d,
              input [7:0] fexp);
    begin
      dout <= ~d;
      u_proc.run(wr, a, d, e, g, o);
      check("ok", {11'h000, o}, 12'h001);
      check("rd", g, ~d);
      check("fld", {4'h0, fld}, {4'h0, fexp});
      check("row", {5'h0, row_s}, {5'h0, v16 & e[2], a[11:6]});
      check("col", {5'h0, col_s}, {5'h0, v16 & e[1], a[5:0]});
      check("cs", {11'h000, cs_s}, {11'h000, v16});
      check("we", {11'h000, we_s}, {11'h000, ~wr});
      if (wr) check("din", din_s, d);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    check("reset", {ras_n, cas_n, cs_n, we_n, rvalid}, 12'hffe);
    for (k = 0; k < 65; k = k + 1) begin
      c = ref_cnt;
      for (n = 0; n < 500 && ref_cnt == c; n = n + 1) @(posedge clock);
      if (n == 500) begin
        bad_count = bad_count + 1;
        wrap_up;
      end
      if (k > 0)
        check("ref", {5'h0, ref_row}, {6'h0, prev[5:0] + 6'h1});
      prev = ref_row;
    end
    $display("refresh test done");
    for (k = 0; k < 8; k = k + 1)
      access(1'b0, {k[2:0], 3'h5, k[2:0], 3'h2}, k[2:0], {k[2:0], 9'h0a5},
             ~(8'h01 << k[2:0]));
    $display("read test done");
    access(1'b1, 12'hfff, 3'h7, 12'h5a5, 8'h7f);
    access(1'b1, 12'h000, 3'h0, 12'ha5a, 8'hfe);
    $display("write test done");
    sel <= 1'b0;
    u_proc.run(1'b0, 12'h123, 12'h000, 3'h1, g, o);
    check("ignored", {11'h000, o}, 12'h000);
    sel <= 1'b1;
    $display("deselect test done");
    v16 <= 1'b1;
    access(1'b0, 12'h2c3, 3'h5, 12'h9e1, 8'hdf);
    access(1'b1, 12'h81f, 3'h2, 12'h36c, 8'hef);
    seg <= 4'h1;
    access(1'b0, 12'h5a6, 3'h1, 12'h0f0, 8'hfd);
    $display("wide chip test done");
    wrap_up;
  end
endmodule
